// ---- event_change_latch.sv ----
// sticky change flags: any edge of a live status bit latches a w1c flag
`timescale 1ns/1ps
module event_change_latch #(
  parameter int WIDTH = 16
) (
  input  wire logic             clock_in,
  input  wire logic             resetn_in,
  input  wire logic [WIDTH-1:0] status_in,
  input  wire logic [WIDTH-1:0] clear_in,
  output logic      [WIDTH-1:0] change_out,
  output logic      [WIDTH-1:0] flags_out
);
  logic             primed_r;
  logic             primed_nxt;
  logic [WIDTH-1:0] prev_r;
  logic [WIDTH-1:0] prev_nxt;
  logic [WIDTH-1:0] flags_r;
  logic [WIDTH-1:0] flags_nxt;

  // first cycle after reset only samples, so a status already high
  // at release does not look like a change
  assign primed_nxt = 1'b1;
  assign prev_nxt   = status_in;

  // per-bit change detect and flag update
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_comb begin
        change_out[i] = primed_r && (status_in[i] != prev_r[i]);
        if (change_out[i]) begin
          flags_nxt[i] = 1'b1;
        end else if (clear_in[i]) begin
          flags_nxt[i] = 1'b0;
        end else begin
          flags_nxt[i] = flags_r[i];
        end
      end
    end
  endgenerate

  // state registers
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      primed_r <= 1'b0;
      prev_r   <= '0;
      flags_r  <= '0;
    end else begin
      primed_r <= primed_nxt;
      prev_r   <= prev_nxt;
      flags_r  <= flags_nxt;
    end
  end

  assign flags_out = flags_r;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!resetn_in);

  set_wins_a: assert property ((|change_out) |=>
    ((flags_out & $past(change_out)) == $past(change_out)))
    else $error("change did not latch its flag");
  clear_works_a: assert property ((|(clear_in & ~change_out)) |=>
    ((flags_out & $past(clear_in & ~change_out)) == '0))
    else $error("write one did not clear flag");
  sticky_hold_a: assert property ((clear_in == '0) |=>
    ((flags_out & $past(flags_out)) == $past(flags_out)))
    else $error("flag dropped without a clear");
  collide_c: cover property (|(change_out & clear_in));
endmodule

// ---- event_host_model.sv ----
// host model: drives the register port and collects read answers
`timescale 1ns/1ps
module event_host_model (
  input  wire logic                      clock_in,
  input  wire metering_event_pkg::word_t reg_rdata_in,
  input  wire logic                      reg_rvalid_in,
  output metering_event_pkg::reg_addr_t  reg_addr_out,
  output logic                           reg_wr_out,
  output logic                           reg_rd_out,
  output metering_event_pkg::word_t      reg_wdata_out
);
  import metering_event_pkg::*;
  // idle port at time zero
  initial begin
    reg_addr_out  = 7'h00;
    reg_wr_out    = 1'b0;
    reg_rd_out    = 1'b0;
    reg_wdata_out = 16'h0000;
  end
  // one write pulse; flags are cleared only by ones in the data
  task automatic write_word(input reg_addr_t addr, input word_t data);
    @(posedge clock_in);
    reg_addr_out  <= addr;
    reg_wdata_out <= data;
    reg_wr_out    <= 1'b1;
    @(posedge clock_in);
    reg_wr_out    <= 1'b0;
    // scrambled when released so stale values never pass for data
    reg_addr_out  <= ~addr;
    reg_wdata_out <= ~data;
  endtask
  // one read pulse; the answer stands from the taking edge for one cycle
  task automatic read_word(input reg_addr_t addr, output word_t data,
                           output logic valid);
    @(posedge clock_in);
    reg_addr_out <= addr;
    reg_rd_out   <= 1'b1;
    @(posedge clock_in);
    reg_rd_out   <= 1'b0;
    reg_addr_out <= ~addr;
    #1;
    valid = reg_rvalid_in;
    data  = reg_rdata_in;
  endtask
endmodule

// ---- metering_event_cfg.svh ----
// constants for the metering event change-flag block
`ifndef METERING_EVENT_CFG_SVH
`define METERING_EVENT_CFG_SVH

// register port addresses
`define EVT_ADDR_W          7
`define EVT_FLAGS_A_ADDR    7'h73
`define EVT_FLAGS_B_ADDR    7'h74
`define EVT_ENABLE_A_ADDR   7'h75

// reset values
`define EVT_FLAGS_RST       16'h0000
`define EVT_ENABLE_RST      16'h0000

// field positions, first flag word (msb of each group)
`define EVT_A_OVERCURRENT   15
`define EVT_A_OVERVOLTAGE   12
`define EVT_A_VOLT_SEQ      9
`define EVT_A_CURR_SEQ      8
`define EVT_A_NEUTRAL_OC    7
`define EVT_A_NOLOAD        6
`define EVT_A_PULSE_DIR     3

// field positions, second flag word
`define EVT_B_FREQ_HIGH     15
`define EVT_B_SAG           14
`define EVT_B_FREQ_LOW      11
`define EVT_B_LOSS          10
`define EVT_B_REACTIVE_SIGN 7
`define EVT_B_ACTIVE_SIGN   3

`endif

// ---- metering_event_irq_flags.sv ----
// event change flags, enable register and interrupt request
`timescale 1ns/1ps
`include "metering_event_cfg.svh"
module metering_event_irq_flags (
  input  wire logic                        clock_in,
  input  wire logic                        resetn_in,
  // register port
  input  wire metering_event_pkg::reg_addr_t reg_addr_in,
  input  wire logic                        reg_wr_in,
  input  wire logic                        reg_rd_in,
  input  wire metering_event_pkg::word_t   reg_wdata_in,
  output metering_event_pkg::word_t        reg_rdata_out,
  output logic                             reg_rvalid_out,
  // live status, first word (A is the msb of each group)
  input  wire logic [2:0]                  overcurrent_state_in,
  input  wire logic [2:0]                  overvoltage_state_in,
  input  wire logic                        volt_sequence_state_in,
  input  wire logic                        curr_sequence_state_in,
  input  wire logic                        neutral_overcurrent_state_in,
  input  wire logic [2:0]                  noload_state_in,
  input  wire logic [3:0]                  pulse_direction_state_in,
  // live status, second word
  input  wire logic                        freq_above_limit_state_in,
  input  wire logic                        freq_below_limit_state_in,
  input  wire logic [2:0]                  sag_state_in,
  input  wire logic [2:0]                  loss_state_in,
  input  wire logic [3:0]                  reactive_sign_state_in,
  input  wire logic [3:0]                  active_sign_state_in,
  // second enable word, held outside this block
  input  wire metering_event_pkg::word_t   enable_b_in,
  // interrupt request and flag words
  output logic                             irq_out,
  output metering_event_pkg::word_t        flags_a_out,
  output metering_event_pkg::word_t        flags_b_out
);
  import metering_event_pkg::*;

  word_t status_a;
  word_t status_b;
  word_t clear_a;
  word_t clear_b;
  word_t change_a;
  word_t change_b;
  word_t flags_a;
  word_t flags_b;
  word_t enable_a_r;
  word_t enable_a_nxt;
  word_t rdata_r;
  word_t rdata_nxt;
  logic  rvalid_r;
  logic  rvalid_nxt;
  logic  wr_flags_a;
  logic  wr_flags_b;
  logic  wr_enable_a;

  // status polarity passes straight through: high means condition present
  always_comb begin
    status_a = '0;
    status_a[`EVT_A_OVERCURRENT -: 3] = overcurrent_state_in;
    status_a[`EVT_A_OVERVOLTAGE -: 3] = overvoltage_state_in;
    status_a[`EVT_A_VOLT_SEQ]         = volt_sequence_state_in;
    status_a[`EVT_A_CURR_SEQ]         = curr_sequence_state_in;
    status_a[`EVT_A_NEUTRAL_OC]     = neutral_overcurrent_state_in;
    status_a[`EVT_A_NOLOAD -: 3]      = noload_state_in;
    status_a[`EVT_A_PULSE_DIR -: 4]   = pulse_direction_state_in;
  end

  // second word: frequency bits sit around the sag group
  always_comb begin
    status_b = '0;
    status_b[`EVT_B_FREQ_HIGH]        = freq_above_limit_state_in;
    status_b[`EVT_B_SAG -: 3]         = sag_state_in;
    status_b[`EVT_B_FREQ_LOW]         = freq_below_limit_state_in;
    status_b[`EVT_B_LOSS -: 3]        = loss_state_in;
    status_b[`EVT_B_REACTIVE_SIGN -: 4] = reactive_sign_state_in;
    status_b[`EVT_B_ACTIVE_SIGN -: 4] = active_sign_state_in;
  end

  // write decode; a write of zero bits leaves flags alone
  assign wr_flags_a  = reg_wr_in && (reg_addr_in == `EVT_FLAGS_A_ADDR);
  assign wr_flags_b  = reg_wr_in && (reg_addr_in == `EVT_FLAGS_B_ADDR);
  assign wr_enable_a = reg_wr_in && (reg_addr_in == `EVT_ENABLE_A_ADDR);
  assign clear_a = wr_flags_a ? reg_wdata_in : '0;
  assign clear_b = wr_flags_b ? reg_wdata_in : '0;

  // first flag word
  event_change_latch #(
    .WIDTH      (16)
  ) u_flags_a (
    .clock_in   (clock_in),
    .resetn_in  (resetn_in),
    .status_in  (status_a),
    .clear_in   (clear_a),
    .change_out (change_a),
    .flags_out  (flags_a)
  );

  // second flag word
  event_change_latch #(
    .WIDTH      (16)
  ) u_flags_b (
    .clock_in   (clock_in),
    .resetn_in  (resetn_in),
    .status_in  (status_b),
    .clear_in   (clear_b),
    .change_out (change_b),
    .flags_out  (flags_b)
  );

  // enable register and read answer, next values
  always_comb begin
    enable_a_nxt = enable_a_r;
    if (wr_enable_a) begin
      enable_a_nxt = reg_wdata_in;
    end
    rvalid_nxt = reg_rd_in;
    rdata_nxt  = rdata_r;
    if (reg_rd_in) begin
      case (reg_addr_in)
        `EVT_FLAGS_A_ADDR:  rdata_nxt = flags_a;
        `EVT_FLAGS_B_ADDR:  rdata_nxt = flags_b;
        `EVT_ENABLE_A_ADDR: rdata_nxt = enable_a_r;
        default:            rdata_nxt = '0; // unmapped reads as zero
      endcase
    end
  end

  // register bank
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      enable_a_r <= `EVT_ENABLE_RST;
      rdata_r    <= '0;
      rvalid_r   <= 1'b0;
    end else begin
      enable_a_r <= enable_a_nxt;
      rdata_r    <= rdata_nxt;
      rvalid_r   <= rvalid_nxt;
    end
  end

  // level request: stays up until every enabled flag is cleared or
  // masked, so a host that misses an edge still sees it
  assign irq_out = |(flags_a & enable_a_r) |
                   |(flags_b & enable_b_in);

  assign reg_rdata_out  = rdata_r;
  assign reg_rvalid_out = rvalid_r;
  assign flags_a_out    = flags_a;
  assign flags_b_out    = flags_b;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!resetn_in);

  enable_write_a: assert property (wr_enable_a |=>
    (enable_a_r == $past(reg_wdata_in)))
    else $error("enable write not stored");
  enable_hold_a: assert property (!wr_enable_a |=> $stable(enable_a_r))
    else $error("enable changed without write");
  // judged against the enable that will stand when the flag shows,
  // so an enable write in the change cycle cannot fire it falsely
  enabled_irq_a: assert property ((|(change_a & enable_a_nxt)) |=>
    irq_out)
    else $error("enabled change raised no interrupt");
  masked_irq_a: assert property (((enable_a_r == '0) &&
    (enable_b_in == '0)) |-> !irq_out)
    else $error("interrupt with all enables off");
  overcurrent_flag_a: assert property (
    $changed(overcurrent_state_in[2]) && $past(resetn_in) |->
    ##1 flags_a[`EVT_A_OVERCURRENT])
    else $error("phase A over-current change not flagged");
  sag_flag_a: assert property (
    $changed(sag_state_in[0]) && $past(resetn_in) |->
    ##1 flags_b[`EVT_B_SAG - 2])
    else $error("phase C sag change not flagged");
  read_answer_a: assert property (reg_rd_in |=> reg_rvalid_out ##1
    (!reg_rvalid_out || $past(reg_rd_in)))
    else $error("read answer timing wrong");
  read_flags_a: assert property ((reg_rd_in && reg_addr_in ==
    `EVT_FLAGS_A_ADDR) |=> (reg_rdata_out == $past(flags_a)))
    else $error("flag word read wrong");
  unmapped_read_a: assert property ((reg_rd_in &&
    reg_addr_in != `EVT_FLAGS_A_ADDR && reg_addr_in != `EVT_FLAGS_B_ADDR
    && reg_addr_in != `EVT_ENABLE_A_ADDR) |=> (reg_rdata_out == '0))
    else $error("unmapped read not zero");
  w1c_clear_a: assert property ((wr_flags_a && (flags_a != '0) &&
    ((reg_wdata_in & change_a) == '0)) |=>
    ((flags_a & $past(reg_wdata_in)) == '0))
    else $error("write one to clear failed");
  w1c_clear_b_a: assert property ((wr_flags_b && (flags_b != '0) &&
    ((reg_wdata_in & change_b) == '0)) |=>
    ((flags_b & $past(reg_wdata_in)) == '0))
    else $error("write one to clear failed on second word");

  // field mapping, checked from the pins so a swapped slice shows up
  oc_c_flag_a: assert property (
    $changed(overcurrent_state_in[0]) && $past(resetn_in) |->
    ##1 flags_a[`EVT_A_OVERCURRENT - 2])
    else $error("phase C over-current change not flagged");
  ov_b_flag_a: assert property (
    $changed(overvoltage_state_in[1]) && $past(resetn_in) |->
    ##1 flags_a[`EVT_A_OVERVOLTAGE - 1])
    else $error("phase B over-voltage change not flagged");
  vseq_flag_a: assert property (
    $changed(volt_sequence_state_in) && $past(resetn_in) |->
    ##1 flags_a[`EVT_A_VOLT_SEQ])
    else $error("voltage sequence change not flagged");
  iseq_flag_a: assert property (
    $changed(curr_sequence_state_in) && $past(resetn_in) |->
    ##1 flags_a[`EVT_A_CURR_SEQ])
    else $error("current sequence change not flagged");
  neutral_flag_a: assert property (
    $changed(neutral_overcurrent_state_in) && $past(resetn_in) |->
    ##1 flags_a[`EVT_A_NEUTRAL_OC])
    else $error("neutral over-current change not flagged");
  noload_flag_a: assert property (
    $changed(noload_state_in[0]) && $past(resetn_in) |->
    ##1 flags_a[`EVT_A_NOLOAD - 2])
    else $error("apparent no-load change not flagged");
  pulse_dir_flag_a: assert property (
    $changed(pulse_direction_state_in[3]) && $past(resetn_in) |->
    ##1 flags_a[`EVT_A_PULSE_DIR])
    else $error("pulse one direction change not flagged");
  pulse4_flag_a: assert property (
    $changed(pulse_direction_state_in[0]) && $past(resetn_in) |->
    ##1 flags_a[`EVT_A_PULSE_DIR - 3])
    else $error("pulse four direction change not flagged");
  freq_high_flag_a: assert property (
    $changed(freq_above_limit_state_in) && $past(resetn_in) |->
    ##1 flags_b[`EVT_B_FREQ_HIGH])
    else $error("frequency high change not flagged");
  freq_low_flag_a: assert property (
    $changed(freq_below_limit_state_in) && $past(resetn_in) |->
    ##1 flags_b[`EVT_B_FREQ_LOW])
    else $error("frequency low change not flagged");
  loss_a_flag_a: assert property (
    $changed(loss_state_in[2]) && $past(resetn_in) |->
    ##1 flags_b[`EVT_B_LOSS])
    else $error("phase A loss change not flagged");
  qsign_flag_a: assert property (
    $changed(reactive_sign_state_in[3]) && $past(resetn_in) |->
    ##1 flags_b[`EVT_B_REACTIVE_SIGN])
    else $error("reactive total sign change not flagged");
  qsign_c_flag_a: assert property (
    $changed(reactive_sign_state_in[0]) && $past(resetn_in) |->
    ##1 flags_b[`EVT_B_REACTIVE_SIGN - 3])
    else $error("reactive phase C sign change not flagged");
  psign_flag_a: assert property (
    $changed(active_sign_state_in[3]) && $past(resetn_in) |->
    ##1 flags_b[`EVT_B_ACTIVE_SIGN])
    else $error("active total sign change not flagged");
  psign_c_flag_a: assert property (
    $changed(active_sign_state_in[0]) && $past(resetn_in) |->
    ##1 flags_b[`EVT_B_ACTIVE_SIGN - 3])
    else $error("active phase C sign change not flagged");

  // each first-word enable group on its own must be able to raise the request
  oc_irq_a: assert property (
    (|(flags_a[`EVT_A_OVERCURRENT -: 3] &
    enable_a_r[`EVT_A_OVERCURRENT -: 3])) |-> irq_out)
    else $error("enabled over-current flag raised no interrupt");
  ov_irq_a: assert property (
    (|(flags_a[`EVT_A_OVERVOLTAGE -: 3] &
    enable_a_r[`EVT_A_OVERVOLTAGE -: 3])) |-> irq_out)
    else $error("enabled over-voltage flag raised no interrupt");
  seq_irq_a: assert property (
    (|(flags_a[`EVT_A_VOLT_SEQ -: 2] &
    enable_a_r[`EVT_A_VOLT_SEQ -: 2])) |-> irq_out)
    else $error("enabled sequence flag raised no interrupt");
  neutral_irq_a: assert property (
    (flags_a[`EVT_A_NEUTRAL_OC] &&
    enable_a_r[`EVT_A_NEUTRAL_OC]) |-> irq_out)
    else $error("enabled neutral flag raised no interrupt");
  noload_irq_a: assert property (
    (|(flags_a[`EVT_A_NOLOAD -: 3] &
    enable_a_r[`EVT_A_NOLOAD -: 3])) |-> irq_out)
    else $error("enabled no-load flag raised no interrupt");
  pulse_irq_a: assert property (
    (|(flags_a[`EVT_A_PULSE_DIR -: 4] &
    enable_a_r[`EVT_A_PULSE_DIR -: 4])) |-> irq_out)
    else $error("enabled direction flag raised no interrupt");

  irq_rise_c:  cover property (!irq_out ##1 irq_out);
  irq_clear_c: cover property (irq_out ##1 wr_flags_a ##1 !irq_out);
  read_c:      cover property (reg_rd_in && reg_addr_in ==
    `EVT_FLAGS_B_ADDR ##1 reg_rdata_out != '0);
endmodule

// ---- metering_event_irq_flags_test.sv ----
// self-checking bench for the event change-flag block
`timescale 1ns/1ps
`include "metering_event_cfg.svh"
module metering_event_irq_flags_test;
  import metering_event_pkg::*;
  logic      clock_in;
  logic      resetn_in;
  reg_addr_t reg_addr;
  logic      reg_wr;
  logic      reg_rd;
  logic      rvalid;
  logic      irq;
  word_t     wdata;
  word_t     rdata;
  word_t     flags_a;
  word_t     flags_b;
  word_t     sa;
  word_t     sb;
  word_t     en_b;
  int        fail_count;
  int        num_checks;

  metering_event_irq_flags metering_event_irq_flags_inst (
    .clock_in(clock_in), .resetn_in(resetn_in), .reg_addr_in(reg_addr),
    .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_wdata_in(wdata),
    .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
    .overcurrent_state_in(sa[15:13]), .overvoltage_state_in(sa[12:10]),
    .volt_sequence_state_in(sa[9]), .curr_sequence_state_in(sa[8]),
    .neutral_overcurrent_state_in(sa[7]), .noload_state_in(sa[6:4]),
    .pulse_direction_state_in(sa[3:0]),
    .freq_above_limit_state_in(sb[15]), .sag_state_in(sb[14:12]),
    .freq_below_limit_state_in(sb[11]), .loss_state_in(sb[10:8]),
    .reactive_sign_state_in(sb[7:4]), .active_sign_state_in(sb[3:0]),
    .enable_b_in(en_b), .irq_out(irq), .flags_a_out(flags_a),
    .flags_b_out(flags_b));

  event_host_model event_host_model_inst (
    .clock_in(clock_in), .reg_rdata_in(rdata), .reg_rvalid_in(rvalid),
    .reg_addr_out(reg_addr), .reg_wr_out(reg_wr), .reg_rd_out(reg_rd),
    .reg_wdata_out(wdata));

  // 250 MHz system clock
  always #2 clock_in = ~clock_in;

  // single compare point; !== so an unknown never passes
  task automatic check(input word_t seen, input word_t exp, input string m);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: %s", $time, m);
    end
  endtask

  // read through the port, answer must be valid
  task automatic read_check(input reg_addr_t a, input word_t exp);
    word_t d;
    logic  v;
    event_host_model_inst.read_word(a, d, v);
    check({15'h0000, v}, 16'h0001, "read answer missing");
    check(d, exp, "read data");
  endtask

  // flip one status bit; the flag shows one edge later
  task automatic toggle(input bit sel_b, input int idx);
    @(posedge clock_in);
    if (sel_b) sb[idx] <= ~sb[idx];
    else sa[idx] <= ~sa[idx];
    @(posedge clock_in);
    #1;
  endtask

  // everything cleared after release; unmapped address reads zero
  task automatic reset_values();
    check(flags_a, 16'h0000, "flags a reset");
    check(flags_b, 16'h0000, "flags b reset");
    read_check(`EVT_ENABLE_A_ADDR, 16'h0000);
    check({15'h0000, irq}, 16'h0000, "irq at reset");
    read_check(7'h10, 16'h0000);
  endtask

  // rising and falling edge each latch the bit; zero writes keep it
  task automatic flag_bit(input bit sel_b, input int idx);
    word_t     exp;
    reg_addr_t a;
    exp = 16'h0001 << idx;
    a   = sel_b ? `EVT_FLAGS_B_ADDR : `EVT_FLAGS_A_ADDR;
    repeat (2) begin
      toggle(sel_b, idx);
      check(sel_b ? flags_b : flags_a, exp, "flag set");
      check(sel_b ? flags_a : flags_b, 16'h0000, "other word");
      read_check(a, exp);
      event_host_model_inst.write_word(a, ~exp);
      #1;
      check(sel_b ? flags_b : flags_a, exp, "zero write kept");
      event_host_model_inst.write_word(a, exp);
      #1;
      check(sel_b ? flags_b : flags_a, 16'h0000, "flag cleared");
    end
  endtask

  // only the matching enable bit lets the flag reach the interrupt
  task automatic irq_bit(input bit sel_b, input int idx);
    word_t exp;
    exp = 16'h0001 << idx;
    if (sel_b) begin
      @(posedge clock_in);
      en_b <= ~exp;
    end else begin
      event_host_model_inst.write_word(`EVT_ENABLE_A_ADDR, ~exp);
    end
    toggle(sel_b, idx);
    check({15'h0000, irq}, 16'h0000, "irq masked");
    if (sel_b) begin
      @(posedge clock_in);
      en_b <= exp;
      #1;
    end else begin
      event_host_model_inst.write_word(`EVT_ENABLE_A_ADDR, exp);
      #1;
      read_check(`EVT_ENABLE_A_ADDR, exp);
    end
    check({15'h0000, irq}, 16'h0001, "irq enabled");
    event_host_model_inst.write_word(
      sel_b ? `EVT_FLAGS_B_ADDR : `EVT_FLAGS_A_ADDR, exp);
    #1;
    check({15'h0000, irq}, 16'h0000, "irq after clear");
  endtask

  // a change in the clearing cycle must not be lost
  task automatic collision();
    toggle(1'b0, 5);
    fork
      event_host_model_inst.write_word(`EVT_FLAGS_A_ADDR, 16'h0020);
      begin
        @(posedge clock_in);
        sa[5] <= ~sa[5];
      end
    join
    #1;
    check(flags_a, 16'h0020, "set beats clear");
    event_host_model_inst.write_word(`EVT_FLAGS_A_ADDR, 16'h0020);
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    clock_in   = 1'b0;
    resetn_in  = 1'b0;
    sa         = 16'h0000;
    sb         = 16'h0000;
    en_b       = 16'h0000;
    fail_count = 0;
    num_checks = 0;
    repeat (3) @(posedge clock_in);
    resetn_in <= 1'b1;
    // first edge after release only samples status
    repeat (2) @(posedge clock_in);
    // look off the edge so register outputs have settled
    #1;
    reset_values();
    for (int i = 0; i < 32; i++) begin
      flag_bit(i[4], i % 16);
    end
    for (int i = 0; i < 32; i++) begin
      irq_bit(i[4], i % 16);
    end
    collision();
    final_report();
  end

  // watchdog: the whole run needs fewer than a thousand cycles
  initial begin
    #100000;
    fail_count++;
    final_report();
  end
endmodule

// ---- metering_event_pkg.sv ----
// types shared by the metering event change-flag block
package metering_event_pkg;
  // one flag, enable or status word
  typedef logic [15:0] word_t;
  // register port address
  typedef logic [6:0]  reg_addr_t;
endpackage
